// ---- shared/ucmc_defines.svh ----
`ifndef UCMC_DEFINES_SVH
`define UCMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets and field positions
// ----------------------------------------------------------------------
`define UCMC_OFF_CTRL 8'h00
`define UCMC_OFF_STATUS 8'h04
`define UCMC_CTRL_INHIBIT 0
`define UCMC_CTRL_RESTART 1
`define UCMC_CTRL_RESET 2'h0
`define UCMC_ST_STATE_LSB 0
`define UCMC_ST_SPEED_LSB 2
`define UCMC_ST_DC_LSB 4
`define UCMC_ST_AC_LSB 6
`define UCMC_ST_CD 8
`define UCMC_ST_COMP 9

// ----------------------------------------------------------------------
// Strap codes from the level comparators
// ----------------------------------------------------------------------
`define UCMC_DC_CODE_LOW 2'h0
`define UCMC_DC_CODE_MID 2'h1
`define UCMC_DC_CODE_HIGH 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UCMC_CLK_MHZ 10
`define UCMC_T_RST_MIN_US 20
`define UCMC_T_STABLE_US 100
`define UCMC_RST_CYC (`UCMC_T_RST_MIN_US * `UCMC_CLK_MHZ)
`define UCMC_CNT_W 8

`endif

// ---- shared/ucmc_pkg.sv ----
package ucmc_pkg;

   typedef enum logic [1:0] {
      UCMC_ST_SHUT = 2'h0,
      UCMC_ST_LATCH = 2'h1,
      UCMC_ST_ACTIVE = 2'h3
   } ucmc_state_e;

   typedef enum logic [1:0] {
      UCMC_SPD_NONE = 2'h0,
      UCMC_SPD_LS = 2'h1,
      UCMC_SPD_FS = 2'h2,
      UCMC_SPD_HS = 2'h3
   } ucmc_speed_e;

   typedef enum logic [1:0] {
      UCMC_DC_40MV = 2'h0,
      UCMC_DC_60MV = 2'h1,
      UCMC_DC_80MV = 2'h2
   } ucmc_dc_e;

   typedef struct packed {
      logic enable;
      ucmc_dc_e dc;
      logic [1:0] ac;
   } ucmc_comp_s;

endpackage : ucmc_pkg

// ---- design/ucmc_in_sync.sv ----
module ucmc_in_sync #(
   parameter int W = 7,
   parameter logic [6:0] RST_VAL = 7'h00
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Raw and filtered levels.
   input wire logic [W-1:0] raw_in,
   output logic [W-1:0] clean_out
);

   logic [W-1:0] ff1_reg;
   logic [W-1:0] ff2_reg;
   logic [W-1:0] ff3_reg;

   // ---------------------------------------------------------------
   // Three stages per bit; the output moves once stages two and three agree.
   // ---------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            ff1_reg[i] <= RST_VAL[i];
            ff2_reg[i] <= RST_VAL[i];
            ff3_reg[i] <= RST_VAL[i];
            clean_out[i] <= RST_VAL[i];
         end else begin
            ff1_reg[i] <= raw_in[i];
            ff2_reg[i] <= ff1_reg[i];
            ff3_reg[i] <= ff2_reg[i];
            if (ff2_reg[i] == ff3_reg[i]) begin
               clean_out[i] <= ff3_reg[i];
            end
         end
      end
   end

endmodule : ucmc_in_sync

// ---- design/ucmc_mode_ctrl.sv ----
// How it works
// - Decode tri-level DC strap: low 40 mV, mid 60 mV, high 80 mV.
// - Four AC boost levels come from the AC strap resistor level code.
// - Low-speed link: compensation off, connection detect high.
// - Full-speed link: compensation off, connection detect high.
// - High-speed link: compensation on with latched boosts, detect high.
// - Shutdown low: no compensation, detect low, channel still passes.
// - Shutdown low for at least 20 us counts as a valid reset.
// - Straps latched only at power-up, release from a valid reset or a CTRL restart write, then ignored.
`include "ucmc_defines.svh"

module ucmc_mode_ctrl
   import ucmc_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and detector levels.
   input wire logic active_low_shutdown,
   input wire logic [1:0] dc_gain_strap,
   input wire logic [1:0] ac_boost_strap,
   input wire logic [1:0] link_speed_raw,
   // Analog control.
   output logic connection_detect_out,
   output ucmc_comp_s comp_out,
   output logic channel_pass
);

   localparam logic [`UCMC_CNT_W-1:0] RST_LAST =
      `UCMC_CNT_W'(`UCMC_RST_CYC - 1);

   logic rst_meta_reg;
   logic rst_n_reg;
   logic [6:0] in_clean;
   logic shut_s;
   logic [1:0] dc_s;
   logic [1:0] ac_s;
   ucmc_speed_e speed_s;
   ucmc_state_e state_reg;
   ucmc_state_e state_next;
   logic [`UCMC_CNT_W-1:0] shut_cnt_reg;
   logic [1:0] dc_lat_reg;
   logic [1:0] ac_lat_reg;
   logic inhibit_reg;
   logic restart_reg;
   logic enabled;
   ucmc_dc_e dc_dec;
   logic wr_en;
   logic setup;
   logic hit;

   // ---------------------------------------------------------------
   // Reset release.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   ucmc_in_sync #(.W(7), .RST_VAL(7'h00)) u_sync (
      .clk(core_clk),
      .rst_n(rst_n_reg),
      .raw_in({link_speed_raw, ac_boost_strap, dc_gain_strap,
               active_low_shutdown}),
      .clean_out(in_clean)
   );

   assign shut_s = in_clean[0];
   assign dc_s = in_clean[2:1];
   assign ac_s = in_clean[4:3];
   assign speed_s = ucmc_speed_e'(in_clean[6:5]);

   // ---------------------------------------------------------------
   // Shutdown pulse width.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         shut_cnt_reg <= '0;
      end else if (shut_s) begin
         shut_cnt_reg <= '0;
      end else if (shut_cnt_reg != RST_LAST) begin
         shut_cnt_reg <= shut_cnt_reg + `UCMC_CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // Mode state machine.
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         UCMC_ST_SHUT: begin
            if (shut_s) begin
               state_next = UCMC_ST_LATCH;
            end
         end
         UCMC_ST_LATCH: begin
            state_next = UCMC_ST_ACTIVE;
         end
         UCMC_ST_ACTIVE: begin
            if (!shut_s && shut_cnt_reg == RST_LAST) begin
               state_next = UCMC_ST_SHUT;
            end else if (restart_reg) begin
               state_next = UCMC_ST_LATCH;
            end
         end
         default: begin
            state_next = UCMC_ST_SHUT;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= UCMC_ST_SHUT;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Strap latches.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dc_lat_reg <= `UCMC_DC_CODE_MID;
         ac_lat_reg <= 2'h0;
      end else if (state_reg == UCMC_ST_LATCH) begin
         dc_lat_reg <= dc_s;
         ac_lat_reg <= ac_s;
      end
   end

   always_comb begin
      case (dc_lat_reg)
         `UCMC_DC_CODE_LOW: dc_dec = UCMC_DC_40MV;
         `UCMC_DC_CODE_HIGH: dc_dec = UCMC_DC_80MV;
         default: dc_dec = UCMC_DC_60MV;
      endcase
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   assign enabled = (state_reg == UCMC_ST_ACTIVE) && shut_s;
   assign channel_pass = 1'b1;

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         connection_detect_out <= 1'b0;
         comp_out <= '{enable: 1'b0, dc: UCMC_DC_60MV, ac: 2'h0};
      end else begin
         connection_detect_out <= enabled && speed_s != UCMC_SPD_NONE;
         comp_out.enable <= enabled && speed_s == UCMC_SPD_HS && !inhibit_reg;
         comp_out.dc <= dc_dec;
         comp_out.ac <= ac_lat_reg;
      end
   end

   // ---------------------------------------------------------------
   // APB slave.
   // ---------------------------------------------------------------
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite;
   assign hit = paddr == `UCMC_OFF_CTRL || paddr == `UCMC_OFF_STATUS;

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         inhibit_reg <= 1'b0;
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= 1'b0;
         if (wr_en && paddr == `UCMC_OFF_CTRL) begin
            inhibit_reg <= pwdata[`UCMC_CTRL_INHIBIT];
            restart_reg <= pwdata[`UCMC_CTRL_RESTART];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !hit;
         prdata <= 32'h0000_0000;
         if (paddr == `UCMC_OFF_CTRL) begin
            prdata[`UCMC_CTRL_INHIBIT] <= inhibit_reg;
         end else if (paddr == `UCMC_OFF_STATUS) begin
            prdata[`UCMC_ST_STATE_LSB +: 2] <= state_reg;
            prdata[`UCMC_ST_SPEED_LSB +: 2] <= speed_s;
            prdata[`UCMC_ST_DC_LSB +: 2] <= dc_lat_reg;
            prdata[`UCMC_ST_AC_LSB +: 2] <= ac_lat_reg;
            prdata[`UCMC_ST_CD] <= connection_detect_out;
            prdata[`UCMC_ST_COMP] <= comp_out.enable;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n_reg);

   sequence s_on(ucmc_speed_e sp);
      enabled && speed_s == sp;
   endsequence

   sequence s_cd_nocomp;
      connection_detect_out && !comp_out.enable;
   endsequence

   AST_DC_DECODE: assert property ((state_reg == UCMC_ST_ACTIVE
      && dc_lat_reg == `UCMC_DC_CODE_LOW) |=> comp_out.dc == UCMC_DC_40MV)
      else $error("DC low strap not mapped to 40 mV.");
   AST_AC_LEVEL: assert property ($rose(state_reg == UCMC_ST_ACTIVE)
      |-> ##1 comp_out.ac == $past(ac_s, 2))
      else $error("AC level differs from strap.");
   AST_LS_MODE: assert property (s_on(UCMC_SPD_LS) |=> s_cd_nocomp)
      else $error("Low speed handling wrong.");
   AST_FS_MODE: assert property (s_on(UCMC_SPD_FS) |=> s_cd_nocomp)
      else $error("Full speed handling wrong.");
   AST_HS_MODE: assert property (enabled && speed_s == UCMC_SPD_HS
      && !inhibit_reg
      |=> connection_detect_out && comp_out.enable)
      else $error("High speed compensation missing.");
   AST_SHUTDOWN: assert property (!shut_s |=> !connection_detect_out
      && !comp_out.enable && channel_pass)
      else $error("Output active during shutdown.");
   AST_VALID_RST: assert property ((state_reg == UCMC_ST_ACTIVE && !shut_s
      && shut_cnt_reg == RST_LAST) |=> state_reg == UCMC_ST_SHUT)
      else $error("Valid reset not recognised.");
   AST_LATCH_ONLY: assert property ((state_reg == UCMC_ST_ACTIVE)
      [*2] |-> $stable(dc_lat_reg) && $stable(ac_lat_reg))
      else $error("Strap changed while active.");
   AST_NO_LINK: assert property (s_on(UCMC_SPD_NONE)
      |=> !connection_detect_out && !comp_out.enable)
      else $error("Detect high without link.");

endmodule : ucmc_mode_ctrl

// ---- verif/ucmc_link_model.sv ----
// ----------------------------------------------------------------------
// Far-side transceiver: shows the wanted speed after a set delay.
// ----------------------------------------------------------------------
module ucmc_link_model (
   // Clock.
   input wire logic core_clk,
   // Commands from the bench.
   input wire logic [1:0] want_speed,
   input wire logic [3:0] attach_delay,
   // Detector level towards the block.
   output logic [1:0] link_speed_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   logic [1:0] pend;

   initial begin
      link_speed_raw = 2'h0;
      wait_cnt = 4'h0;
      pend = 2'h0;
   end

   always @(posedge core_clk) begin
      if (want_speed != pend) begin
         pend <= want_speed;
         wait_cnt <= attach_delay;
      end else if (wait_cnt != 4'h0) begin
         wait_cnt <= wait_cnt - 4'h1;
      end else begin
         link_speed_raw <= pend;
      end
   end
endmodule : ucmc_link_model

// ---- verif/tb_top.sv ----
module tb_top
   import ucmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic shut_n, cd, pass;
   logic [1:0] dc_s, ac_s, want, spd;
   logic [3:0] dly;
   ucmc_comp_s comp;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [1:0] dcode [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   ucmc_dc_e dexp [4] = '{UCMC_DC_40MV, UCMC_DC_60MV, UCMC_DC_80MV,
      UCMC_DC_60MV};

   ucmc_mode_ctrl uut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .active_low_shutdown(shut_n), .dc_gain_strap(dc_s),
      .ac_boost_strap(ac_s), .link_speed_raw(spd),
      .connection_detect_out(cd), .comp_out(comp), .channel_pass(pass));
   ucmc_link_model far (.core_clk(core_clk), .want_speed(want),
      .attach_delay(dly), .link_speed_raw(spd));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic chk_comp(input ucmc_comp_s e);
      checks_done++;
      if (comp !== e) begin
         num_errors++;
         $display("CHECK FAILED comp_out expected %h seen %h", e, comp);
      end
   endtask : chk_comp

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic link(input logic [1:0] s, input logic [3:0] d);
      @(posedge core_clk);
      want <= s;
      dly <= d;
      cyc(d + 16);
   endtask : link

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      shut_n = 1'b0;
      dc_s = 2'h0;
      ac_s = 2'h2;
      want = 2'h0;
      dly = 4'h0;
      cyc(3);
      arst_n <= 1'b1;
      cyc(1000);
      shut_n <= 1'b1;
      cyc(14);
      chk("cd idle", 1'b0, cd);
      chk("en idle", 1'b0, comp.enable);
      for (int s = 1; s < 4; s++) begin
         link(2'(s), 4'(4 * s));
         chk("cd linked", 1'b1, cd);
         chk("en by speed", (s == 3), comp.enable);
      end
      chk_comp('{1'b1, UCMC_DC_40MV, 2'h2});
      $display("speed test done");
      apb(1'b0, 8'h04, 32'h0);
      chk("status", 32'h38f, q & 32'h3ff);
      chk("status err", 1'b0, err);
      chk("pready", 1'b1, pready);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped err", 1'b1, err);
      apb(1'b1, 8'h00, 32'h1);
      cyc(2);
      chk("inhibit", 1'b0, comp.enable);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h1, q);
      apb(1'b1, 8'h00, 32'h0);
      cyc(2);
      chk("uninhibit", 1'b1, comp.enable);
      $display("register test done");
      dc_s <= 2'h1;
      ac_s <= 2'h1;
      cyc(14);
      chk_comp('{1'b1, UCMC_DC_40MV, 2'h2});
      shut_n <= 1'b0;
      cyc(8);
      chk("cd shut", 1'b0, cd);
      chk("en shut", 1'b0, comp.enable);
      chk("pass shut", 1'b1, pass);
      cyc(40);
      shut_n <= 1'b1;
      cyc(14);
      chk_comp('{1'b1, UCMC_DC_40MV, 2'h2});
      $display("short shutdown test done");
      for (int i = 0; i < 4; i++) begin
         shut_n <= 1'b0;
         dc_s <= dcode[i];
         ac_s <= 2'(i);
         cyc(210);
         shut_n <= 1'b1;
         cyc(14);
         chk_comp('{1'b1, dexp[i], 2'(i)});
      end
      $display("strap test done");
      dc_s <= 2'h0;
      ac_s <= 2'h1;
      cyc(6);
      chk_comp('{1'b1, UCMC_DC_60MV, 2'h3});
      apb(1'b1, 8'h00, 32'h2);
      cyc(10);
      chk_comp('{1'b1, UCMC_DC_40MV, 2'h1});
      apb(1'b0, 8'h00, 32'h0);
      chk("restart reads 0", 32'h0, q);
      $display("restart test done");
      link(2'h0, 4'h0);
      chk("cd gone", 1'b0, cd);
      chk("en gone", 1'b0, comp.enable);
      $display("disconnect test done");
      arst_n <= 1'b0;
      cyc(2);
      chk("cd reset", 1'b0, cd);
      chk_comp('{1'b0, UCMC_DC_60MV, 2'h0});
      chk("prdata reset", 32'h0, prdata);
      $display("reset test done");
      report_and_stop();
   end
endmodule : tb_top
